// >>> mebp_bus.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: mode pins sampled during reset set mode
// RULE_02: mode pins pulled down during reset
// RULE_03: mode pins become queue tracking or gpio
// RULE_04: queue state time-multiplexed on tracking pins
// RULE_05: special mode pin reused as debug or tag
// RULE_06: ports gpio single-chip, bus when expanded
// RULE_07: wide: upper high byte, lower low byte
// RULE_08: narrow: address both ports, data upper only
// RULE_09: narrow word: high byte then low byte
// RULE_10: outside logic latches address at clock rise
// RULE_11: read/write pin gpio until enabled, gates writes
// RULE_12: strobe pin gpio until enabled, gates writes
// RULE_13: strobe pin doubles as tag low input
// RULE_14: bus enable low during bus clock high
// RULE_15: stretched: enable only in final quarter
// RULE_16: enable on reads only, disable bit, on
// RULE_17: bus enable pulled up in single-chip modes
// RULE_18: device drives bus clock out
// RULE_19: strobe is xnor of addr bit0, size
// RULE_20: bus clock half crystal, stretchable; here stretch adds whole bus clock periods, bus_clock_out keeps its rate
// RULE_21: read/write high read, low write, whole cycle
module mebp_bus import mebp_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [MEBP_AW-1:0] reg_addr,
	input wire logic [MEBP_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [MEBP_DW-1:0] reg_rdata,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic byte_size_access_n,
	input wire logic [15:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	output logic acc_ready,
	output logic acc_done,
	output logic [15:0] acc_rdata,
	input wire logic [3:0] queue_state,
	input wire logic dbg_tx,
	input wire logic dbg_tx_en,
	output logic dbg_rx,
	output logic tag_high_input,
	output logic tag_low_input,
	input wire logic [7:0] upper_bus_port_in,
	output logic [7:0] upper_bus_port_out,
	output logic [7:0] upper_bus_port_oe,
	input wire logic [7:0] lower_bus_port_in,
	output logic [7:0] lower_bus_port_out,
	output logic [7:0] lower_bus_port_oe,
	input wire logic rw_in,
	output logic rw_out,
	output logic rw_oe,
	output logic rw_pullup,
	input wire logic low_byte_strobe_in,
	output logic low_byte_strobe_out,
	output logic low_byte_strobe_oe,
	output logic low_byte_strobe_pullup,
	output logic data_bus_enable_n,
	output logic data_bus_enable_oe,
	output logic data_bus_enable_pullup,
	input wire logic mode_select_a_in,
	output logic mode_select_a_out,
	output logic mode_select_a_oe,
	input wire logic mode_select_b_in,
	output logic mode_select_b_out,
	output logic mode_select_b_oe,
	output logic mode_pulldown_en,
	input wire logic special_mode_select_n_in,
	output logic special_mode_select_n_out,
	output logic special_mode_select_n_oe,
	output logic bus_clock_out
);
	logic [2:0] mode;
	logic [MEBP_DW-1:0] pin_assignment_reg;
	logic [7:0] upper_data, upper_dir, lower_data, lower_dir;
	logic [7:0] misc_data, misc_dir;
	logic [1:0] quarter;
	logic sub_first, sub_last, stretched, cyc_end;
	mebp_state_t state;
	mebp_state_t next_state;
	logic p_write, p_sz8_n;
	logic [15:0] p_addr, p_wdata;
	logic expanded, wide, special, in_bus, addr_phase, bus_clock_out_high;
	logic read_write_enable_bit, low_strobe_enable_bit;
	logic bus_enable_disable_bit, qtrk_en, tag_sel;
	logic blocked, take, last_beat, p_pend;
	logic [15:0] cur_addr;
	logic [7:0] next_up_out, next_up_oe, next_lo_out, next_lo_oe;
	logic next_dbe_n;
	assign expanded = mebp_expanded(mode);
	assign wide = mebp_wide(mode);
	assign special = ~mode[MEBP_MODE_S];
	assign read_write_enable_bit = pin_assignment_reg[MEBP_B_READ_WRITE_ENABLE_BIT];
	assign low_strobe_enable_bit = pin_assignment_reg[MEBP_B_LOW_STROBE_ENABLE_BIT];
	assign bus_enable_disable_bit = pin_assignment_reg[MEBP_B_BUS_ENABLE_DISABLE_BIT];
	assign qtrk_en = pin_assignment_reg[MEBP_B_QTRK];
	assign tag_sel = pin_assignment_reg[MEBP_B_TAGSEL];
	assign bus_clock_out_high = quarter >= MEBP_Q_HIGH;
	assign in_bus = (state != MEBP_IDLE);
	assign addr_phase = sub_first && !bus_clock_out_high;
	mebp_mode_latch u_mode (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.special_n_in(special_mode_select_n_in),
		.mode_b_in(mode_select_b_in),
		.mode_a_in(mode_select_a_in),
		.mode(mode)
	);
	mebp_bus_clock_out_gen u_bus_clock_out (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.stretch_in(pin_assignment_reg[MEBP_B_STR_HI:MEBP_B_STR_LO]),
		.quarter(quarter),
		.sub_first(sub_first),
		.sub_last(sub_last),
		.stretched(stretched),
		.cyc_end(cyc_end)
	);
	// register file
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pin_assignment_reg <= MEBP_PIN_ASSIGN_RST; // RULE_16
			upper_data <= MEBP_ZERO8;
			upper_dir <= MEBP_ZERO8;
			lower_data <= MEBP_ZERO8;
			lower_dir <= MEBP_ZERO8;
			misc_data <= MEBP_ZERO8;
			misc_dir <= MEBP_ZERO8; // RULE_11 RULE_12
		end else if (ce && reg_wr) begin
			case (reg_addr)
			MEBP_REG_PIN_ASSIGN: pin_assignment_reg <= reg_wdata;
			MEBP_REG_UPPER_DATA: upper_data <= reg_wdata;
			MEBP_REG_UPPER_DIR: upper_dir <= reg_wdata;
			MEBP_REG_LOWER_DATA: lower_data <= reg_wdata;
			MEBP_REG_LOWER_DIR: lower_dir <= reg_wdata;
			MEBP_REG_MISC_DATA: misc_data <= reg_wdata;
			MEBP_REG_MISC_DIR: misc_dir <= reg_wdata;
			default: ;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= MEBP_ZERO8;
		end else if (ce) begin
			reg_rdata <= MEBP_ZERO8;
			if (reg_rd) begin
				case (reg_addr)
				MEBP_REG_PIN_ASSIGN: reg_rdata <= pin_assignment_reg;
				MEBP_REG_UPPER_DATA: reg_rdata <= upper_bus_port_in;
				MEBP_REG_UPPER_DIR: reg_rdata <= upper_dir;
				MEBP_REG_LOWER_DATA: reg_rdata <= lower_bus_port_in;
				MEBP_REG_LOWER_DIR: reg_rdata <= lower_dir;
				MEBP_REG_MISC_DATA: reg_rdata <= {4'h0, mode_select_b_in,
					mode_select_a_in, low_byte_strobe_in, rw_in};
				MEBP_REG_MISC_DIR: reg_rdata <= misc_dir;
				MEBP_REG_STATUS: reg_rdata <= {2'h0, tag_low_input,
					tag_high_input, in_bus, mode};
				default: reg_rdata <= MEBP_ZERO8;
				endcase
			end
		end
	end
	// a write with read/write off, or a wide write needing the low strobe with the strobe off, never reaches the bus
	assign blocked = acc_write && (!read_write_enable_bit // RULE_11
		|| (!low_strobe_enable_bit && wide // RULE_12
		&& !mebp_low_byte_strobe(acc_addr[0], byte_size_access_n)));
	assign acc_ready = (state == MEBP_IDLE) && !p_pend && expanded;
	assign take = ce && acc_req && acc_ready;
	assign last_beat = wide || !p_sz8_n || (state == MEBP_BUS2);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			p_pend <= 1'b0;
			p_write <= 1'b0;
			p_sz8_n <= 1'b1;
			p_addr <= 16'h0000;
			p_wdata <= 16'h0000;
		end else if (take && !blocked) begin
			p_pend <= 1'b1;
			p_write <= acc_write;
			p_sz8_n <= byte_size_access_n;
			p_addr <= acc_addr;
			p_wdata <= acc_wdata;
		end else if (cyc_end && state == MEBP_IDLE) begin
			p_pend <= 1'b0;
		end
	end
	always_comb begin
		next_state = state;
		case (state)
		MEBP_IDLE: if (p_pend) next_state = MEBP_BUS1;
		MEBP_BUS1: next_state = last_beat ? MEBP_IDLE : MEBP_BUS2; // RULE_09
		MEBP_BUS2: next_state = MEBP_IDLE;
		default: next_state = MEBP_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			state <= MEBP_IDLE;
		else if (cyc_end)
			state <= next_state;
	end
	// narrow second beat addresses the low byte
	assign cur_addr = (state == MEBP_BUS2) ? (p_addr | 16'h0001) : p_addr;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_done <= 1'b0;
			acc_rdata <= 16'h0000;
		end else if (ce) begin
			acc_done <= (take && blocked) || (cyc_end && in_bus && last_beat);
			if (cyc_end && in_bus && !p_write) begin
				if (wide)
					acc_rdata <= {upper_bus_port_in, lower_bus_port_in}; // RULE_07
				else if (state == MEBP_BUS2)
					acc_rdata[7:0] <= upper_bus_port_in; // RULE_09
				else if (p_sz8_n)
					acc_rdata[15:8] <= upper_bus_port_in;
				else
					acc_rdata <= {8'h00, upper_bus_port_in}; // RULE_08
			end
		end
	end
	// address/data lanes
	always_comb begin
		next_up_out = upper_data;
		next_up_oe = upper_dir;
		next_lo_out = lower_data;
		next_lo_oe = lower_dir; // RULE_06
		if (expanded) begin
			next_up_oe = MEBP_ZERO8;
			next_lo_oe = MEBP_ZERO8;
			if (in_bus && addr_phase) begin
				next_up_out = cur_addr[15:8];
				next_lo_out = cur_addr[7:0];
				next_up_oe = 8'hFF;
				next_lo_oe = 8'hFF;
			end else if (in_bus && wide) begin
				next_up_out = p_wdata[15:8];
				next_lo_out = p_wdata[7:0]; // RULE_07
				next_up_oe = {8{p_write}};
				next_lo_oe = {8{p_write}};
			end else if (in_bus) begin
				next_up_out = (state == MEBP_BUS2 || !p_sz8_n) ?
					p_wdata[7:0] : p_wdata[15:8]; // RULE_08
				next_lo_out = cur_addr[7:0];
				next_up_oe = {8{p_write}};
				next_lo_oe = 8'hFF;
			end
		end
	end
	// bus enable: reads only, high time, last quarter when stretched
	always_comb begin
		next_dbe_n = 1'b1;
		if (in_bus && !p_write && bus_clock_out_high && sub_last) // RULE_14 RULE_16
			next_dbe_n = stretched && (quarter != MEBP_Q_LAST); // RULE_15
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			upper_bus_port_out <= MEBP_ZERO8;
			upper_bus_port_oe <= MEBP_ZERO8;
			lower_bus_port_out <= MEBP_ZERO8;
			lower_bus_port_oe <= MEBP_ZERO8;
			bus_clock_out <= 1'b0;
			data_bus_enable_n <= 1'b1;
			data_bus_enable_oe <= 1'b0;
		end else if (ce) begin
			upper_bus_port_out <= next_up_out;
			upper_bus_port_oe <= next_up_oe;
			lower_bus_port_out <= next_lo_out;
			lower_bus_port_oe <= next_lo_oe;
			bus_clock_out <= bus_clock_out_high; // RULE_18 RULE_20
			data_bus_enable_n <= next_dbe_n;
			data_bus_enable_oe <= expanded && !bus_enable_disable_bit; // RULE_16
		end
	end
	assign data_bus_enable_pullup = sys_rst || !expanded; // RULE_17
	// control pins: function when enabled in an expanded mode, gpio otherwise
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rw_out <= 1'b1;
			rw_oe <= 1'b0;
			low_byte_strobe_out <= 1'b1;
			low_byte_strobe_oe <= 1'b0;
		end else if (ce) begin
			if (expanded && read_write_enable_bit) begin
				rw_out <= !(in_bus && p_write); // RULE_21
				rw_oe <= 1'b1; // RULE_11
			end else begin
				rw_out <= misc_data[MEBP_M_RW];
				rw_oe <= misc_dir[MEBP_M_RW];
			end
			// strobe pin released between cycles so tag low can be read
			if (expanded && low_strobe_enable_bit) begin
				low_byte_strobe_out <= mebp_low_byte_strobe(cur_addr[0], p_sz8_n); // RULE_19
				low_byte_strobe_oe <= in_bus; // RULE_12 RULE_13
			end else begin
				low_byte_strobe_out <= misc_data[MEBP_M_LOW_BYTE_STROBE];
				low_byte_strobe_oe <= misc_dir[MEBP_M_LOW_BYTE_STROBE];
			end
		end
	end
	assign rw_pullup = !rw_oe; // RULE_11
	assign low_byte_strobe_pullup = !low_byte_strobe_oe; // RULE_12
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tag_low_input <= 1'b0;
			tag_high_input <= 1'b0;
			dbg_rx <= 1'b1;
		end else if (ce) begin
			if (special && expanded && !low_byte_strobe_oe)
				tag_low_input <= low_byte_strobe_in; // RULE_13
			if (tag_sel)
				tag_high_input <= special_mode_select_n_in; // RULE_05
			else
				dbg_rx <= special_mode_select_n_in;
		end
	end
	// mode pins: tracking shows low pair in low time, high pair in high time
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_select_a_out <= 1'b0;
			mode_select_a_oe <= 1'b0;
			mode_select_b_out <= 1'b0;
			mode_select_b_oe <= 1'b0;
			special_mode_select_n_out <= 1'b1;
			special_mode_select_n_oe <= 1'b0;
		end else if (ce) begin
			if (qtrk_en) begin
				mode_select_a_out <= bus_clock_out_high ? queue_state[2] : queue_state[0];
				mode_select_b_out <= bus_clock_out_high ? queue_state[3] : queue_state[1];
				mode_select_a_oe <= 1'b1; // RULE_03 RULE_04
				mode_select_b_oe <= 1'b1;
			end else begin
				mode_select_a_out <= misc_data[MEBP_M_MODE_SELECT_A];
				mode_select_b_out <= misc_data[MEBP_M_MODE_SELECT_B];
				mode_select_a_oe <= misc_dir[MEBP_M_MODE_SELECT_A]; // RULE_03
				mode_select_b_oe <= misc_dir[MEBP_M_MODE_SELECT_B];
			end
			special_mode_select_n_out <= dbg_tx;
			special_mode_select_n_oe <= dbg_tx_en && !tag_sel; // RULE_05
		end
	end
	assign mode_pulldown_en = sys_rst; // RULE_02
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	mode_hold_a: assert property (!$past(sys_rst) |-> $stable(mode)) // RULE_01
		else $error("mode changed after reset");
	pulldown_rst_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		sys_rst ##1 sys_rst |-> mode_pulldown_en && !mode_select_a_oe
		&& !mode_select_b_oe) // RULE_02
		else $error("mode pins not released under reset");
	rw_gate_a: assert property (rw_oe && !rw_out && !$past(misc_dir[MEBP_M_RW])
		|-> $past(read_write_enable_bit)) // RULE_11
		else $error("write driven while read/write disabled");
	dbe_high_a: assert property (data_bus_enable_oe && !data_bus_enable_n
		|-> bus_clock_out && upper_bus_port_oe == MEBP_ZERO8) // RULE_14
		else $error("bus enable outside clock high or with drive");
	dbe_stretch_a: assert property ($fell(data_bus_enable_n) && $past(ce)
		&& $past(stretched) |=> ce |-> data_bus_enable_n) // RULE_15
		else $error("stretched bus enable longer than a quarter");
	bus_clock_out_rate_a: assert property ($rose(bus_clock_out) ##0 ce[*2]
		|=> $fell(bus_clock_out)) // RULE_20
		else $error("bus clock high time wrong");
	narrow_split_a: assert property (cyc_end && state == MEBP_BUS1 && !wide
		&& p_sz8_n |=> state == MEBP_BUS2) // RULE_09
		else $error("narrow word not split");
	gpio_single_a: assert property (!expanded && $past(ce) && !$past(sys_rst)
		|-> upper_bus_port_oe == $past(upper_dir)) // RULE_06
		else $error("port not gpio in single chip");
	dbe_pull_a: assert property (!expanded |-> data_bus_enable_pullup) // RULE_17
		else $error("bus enable pullup missing");
	narrow_word_c: cover property (state == MEBP_BUS1 ##[1:40]
		state == MEBP_BUS2);
	wide_read_c: cover property (wide && !data_bus_enable_n && !p_write);
	stretch_c: cover property (stretched && !data_bus_enable_n);
	blocked_c: cover property (take && blocked);
endmodule
`default_nettype wire

// >>> mebp_bus_clock_out_gen.sv
`timescale 1ns/1ps
`default_nettype none
// four sys_clk quarters per bus clock period
module mebp_bus_clock_out_gen import mebp_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [1:0] stretch_in,
	output logic [1:0] quarter,
	output logic sub_first,
	output logic sub_last,
	output logic stretched,
	output logic cyc_end
);
	logic [1:0] sub;
	logic [1:0] str;
	assign sub_first = (sub == MEBP_STR_RST);
	assign sub_last = (sub == str);
	assign stretched = (str != MEBP_STR_RST);
	assign cyc_end = ce && (quarter == MEBP_Q_LAST) && sub_last;
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			quarter <= 2'h0;
		else if (ce)
			quarter <= quarter + 2'h1;
	end
	// stretch is only taken at a cycle boundary so a cycle never changes length
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sub <= MEBP_STR_RST;
			str <= MEBP_STR_RST;
		end else if (ce && quarter == MEBP_Q_LAST) begin
			if (sub_last) begin
				sub <= MEBP_STR_RST;
				str <= stretch_in;
			end else begin
				sub <= sub + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> mebp_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
// memory on the far side of the multiplexed bus
module mebp_ext_mem (
	input wire logic sys_clk,
	input wire logic narrow,
	input wire logic bus_clock_out,
	input wire logic data_bus_enable_n,
	input wire logic rw_out,
	input wire logic low_byte_strobe_out,
	input wire logic [7:0] upper_bus_port_out,
	input wire logic [7:0] upper_bus_port_oe,
	input wire logic [7:0] lower_bus_port_out,
	output logic [7:0] upper_drv,
	output logic [7:0] lower_drv,
	output logic [15:0] lat_addr,
	output logic [15:0] lat_wdata,
	output logic lat_rw,
	output logic lat_strb,
	output int n_beat,
	output int n_dbe
);
	logic prev_clk = 1'h0;
	logic prev_oe = 1'h0;
	logic serve;
	logic [15:0] word;
	logic [7:0] last_up = 8'h00;
	logic [7:0] last_lo = 8'h00;
	initial n_beat = 0;
	initial n_dbe = 0;
	assign serve = bus_clock_out && rw_out && (upper_bus_port_oe == 8'h00);
	assign word = {lat_addr[7:0] ^ 8'hA5, lat_addr[15:8] ^ 8'h3C};
	// released lines show the inverse of the last value, not a held copy
	assign upper_drv = !serve ? ~last_up :
		(narrow && lat_addr[0]) ? word[7:0] : word[15:8];
	assign lower_drv = (serve && !narrow) ? word[7:0] : ~last_lo;
	always @(posedge sys_clk) begin
		prev_clk <= bus_clock_out;
		prev_oe <= &upper_bus_port_oe;
		// transparent latch: follows the address while the clock is low
		if (!bus_clock_out && (&upper_bus_port_oe)) begin
			lat_addr <= {upper_bus_port_out, lower_bus_port_out};
			lat_rw <= rw_out;
			lat_strb <= low_byte_strobe_out;
		end
		if (bus_clock_out && !prev_clk && prev_oe)
			n_beat <= n_beat + 1;
		if (!data_bus_enable_n)
			n_dbe <= n_dbe + 1;
		if (bus_clock_out && !rw_out && (&upper_bus_port_oe))
			lat_wdata <= {upper_bus_port_out, lower_bus_port_out};
		last_up <= upper_drv;
		last_lo <= lower_drv;
	end
endmodule
`default_nettype wire

// >>> mebp_mode_latch.sv
`timescale 1ns/1ps
`default_nettype none
module mebp_mode_latch import mebp_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic special_n_in,
	input wire logic mode_b_in,
	input wire logic mode_a_in,
	output logic [2:0] mode
);
	// level follows the straps for as long as reset lasts, then holds
	always_ff @(posedge sys_clk) begin
		if (sys_rst && ce)
			mode <= {special_n_in, mode_b_in, mode_a_in}; // RULE_01
	end
endmodule
`default_nettype wire

// >>> mebp_pkg.sv
package mebp_pkg;
	localparam int MEBP_AW = 4;
	localparam int MEBP_DW = 8;
	localparam logic [MEBP_AW-1:0] MEBP_REG_PIN_ASSIGN = 4'h0;
	localparam logic [MEBP_AW-1:0] MEBP_REG_UPPER_DATA = 4'h1;
	localparam logic [MEBP_AW-1:0] MEBP_REG_UPPER_DIR = 4'h2;
	localparam logic [MEBP_AW-1:0] MEBP_REG_LOWER_DATA = 4'h3;
	localparam logic [MEBP_AW-1:0] MEBP_REG_LOWER_DIR = 4'h4;
	localparam logic [MEBP_AW-1:0] MEBP_REG_MISC_DATA = 4'h5;
	localparam logic [MEBP_AW-1:0] MEBP_REG_MISC_DIR = 4'h6;
	localparam logic [MEBP_AW-1:0] MEBP_REG_STATUS = 4'h7;
	// pin assignment register fields
	localparam int MEBP_B_READ_WRITE_ENABLE_BIT = 0;
	localparam int MEBP_B_LOW_STROBE_ENABLE_BIT = 1;
	localparam int MEBP_B_BUS_ENABLE_DISABLE_BIT = 2;
	localparam int MEBP_B_QTRK = 3;
	localparam int MEBP_B_STR_LO = 4;
	localparam int MEBP_B_STR_HI = 5;
	localparam int MEBP_B_TAGSEL = 6;
	localparam logic [MEBP_DW-1:0] MEBP_PIN_ASSIGN_RST = 8'h00;
	// misc port bits
	localparam int MEBP_M_RW = 0;
	localparam int MEBP_M_LOW_BYTE_STROBE = 1;
	localparam int MEBP_M_MODE_SELECT_A = 2;
	localparam int MEBP_M_MODE_SELECT_B = 3;
	localparam logic [MEBP_DW-1:0] MEBP_ZERO8 = 8'h00;
	localparam logic [1:0] MEBP_Q_LAST = 2'h3;
	localparam logic [1:0] MEBP_Q_HIGH = 2'h2;
	localparam logic [1:0] MEBP_STR_RST = 2'h0;
	// mode word is {special_n, mode_b, mode_a}
	localparam int MEBP_MODE_A = 0;
	localparam int MEBP_MODE_B = 1;
	localparam int MEBP_MODE_S = 2;
	typedef enum logic [1:0] {
		MEBP_IDLE = 2'h0,
		MEBP_BUS1 = 2'h1,
		MEBP_BUS2 = 2'h2
	} mebp_state_t;
	function automatic logic mebp_expanded(input logic [2:0] m);
		return m[MEBP_MODE_A];
	endfunction
	function automatic logic mebp_wide(input logic [2:0] m);
		return m[MEBP_MODE_A] & m[MEBP_MODE_B];
	endfunction
	function automatic logic mebp_low_byte_strobe(input logic a0, input logic sz8_n);
		return ~(a0 ^ sz8_n);
	endfunction
endpackage

// >>> multiplexed_external_bus_pins_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module multiplexed_external_bus_pins_tb_top import mebp_pkg::*;;
	logic sys_clk = 1'h0, sys_rst = 1'h1, ce = 1'h1, dbg_tx = 1'h0;
	logic dbg_tx_en = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, acc_req = 1'h0;
	logic acc_write = 1'h0, byte_size_access_n = 1'h1, narrow = 1'h0;
	logic [3:0] reg_addr = 4'h0, queue_state = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [15:0] acc_addr = 16'h0000, acc_wdata = 16'h0000, acc_rdata;
	logic [2:0] mode_pins = 3'h7;
	logic acc_ready, acc_done, dbg_rx, tag_high_input, tag_low_input;
	logic [7:0] upper_bus_port_in, upper_bus_port_out, upper_bus_port_oe;
	logic [7:0] lower_bus_port_in, lower_bus_port_out, lower_bus_port_oe;
	logic [7:0] upper_drv, lower_drv;
	logic rw_in, rw_out, rw_oe, rw_pullup, low_byte_strobe_in;
	logic low_byte_strobe_out, low_byte_strobe_oe, low_byte_strobe_pullup;
	logic data_bus_enable_n, data_bus_enable_oe, data_bus_enable_pullup;
	logic mode_select_a_in, mode_select_a_out, mode_select_a_oe;
	logic mode_select_b_in, mode_select_b_out, mode_select_b_oe;
	logic mode_pulldown_en, special_mode_select_n_in, special_mode_select_n_out;
	logic special_mode_select_n_oe, bus_clock_out, lat_rw, lat_strb;
	logic [15:0] lat_addr, lat_wdata;
	int n_beat, n_dbe, err_count = 0, n_compared = 0, cyc = 0;
	// pin levels: whoever enables wins, otherwise the far side on the ports, the straps on the mode pins, pullups elsewhere
	assign upper_bus_port_in = (upper_bus_port_oe & upper_bus_port_out) |
		(~upper_bus_port_oe & upper_drv);
	assign lower_bus_port_in = (lower_bus_port_oe & lower_bus_port_out) |
		(~lower_bus_port_oe & lower_drv);
	assign rw_in = rw_oe ? rw_out : 1'h1;
	assign low_byte_strobe_in = low_byte_strobe_oe ? low_byte_strobe_out : 1'h1;
	assign mode_select_a_in = mode_select_a_oe ? mode_select_a_out : mode_pins[0];
	assign mode_select_b_in = mode_select_b_oe ? mode_select_b_out : mode_pins[1];
	assign special_mode_select_n_in = special_mode_select_n_oe ?
		special_mode_select_n_out : mode_pins[2];
	mebp_bus u_dut (.sys_clk, .sys_rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .acc_req, .acc_write, .byte_size_access_n,
		.acc_addr, .acc_wdata, .acc_ready, .acc_done, .acc_rdata, .queue_state,
		.dbg_tx, .dbg_tx_en, .dbg_rx, .tag_high_input, .tag_low_input,
		.upper_bus_port_in, .upper_bus_port_out, .upper_bus_port_oe,
		.lower_bus_port_in, .lower_bus_port_out, .lower_bus_port_oe, .rw_in,
		.rw_out, .rw_oe, .rw_pullup, .low_byte_strobe_in, .low_byte_strobe_out,
		.low_byte_strobe_oe, .low_byte_strobe_pullup, .data_bus_enable_n,
		.data_bus_enable_oe, .data_bus_enable_pullup, .mode_select_a_in,
		.mode_select_a_out, .mode_select_a_oe, .mode_select_b_in,
		.mode_select_b_out, .mode_select_b_oe, .mode_pulldown_en,
		.special_mode_select_n_in, .special_mode_select_n_out,
		.special_mode_select_n_oe, .bus_clock_out);
	mebp_ext_mem u_mem (.sys_clk, .narrow, .bus_clock_out, .data_bus_enable_n,
		.rw_out, .low_byte_strobe_out, .upper_bus_port_out, .upper_bus_port_oe,
		.lower_bus_port_out, .upper_drv, .lower_drv, .lat_addr, .lat_wdata,
		.lat_rw, .lat_strb, .n_beat, .n_dbe);
	always #20 sys_clk = ~sys_clk;
	function automatic logic [15:0] exp_word(input logic [15:0] a);
		return {a[7:0] ^ 8'hA5, a[15:8] ^ 8'h3C};
	endfunction
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
	task automatic access(input logic w, input logic s, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] r);
		@(posedge sys_clk);
		acc_req <= 1'h1;
		acc_write <= w;
		byte_size_access_n <= s;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge sys_clk iff acc_ready);
		acc_req <= 1'h0;
		@(posedge sys_clk iff acc_done);
		r = acc_rdata;
		// far-side counters move on this same edge; read them once settled
		@(negedge sys_clk);
	endtask
	task automatic do_reset(input logic [2:0] m);
		@(posedge sys_clk);
		sys_rst <= 1'h1;
		mode_pins <= m;
		narrow <= m[0] & ~m[1];
		repeat (20) @(posedge sys_clk);
		chk("pulldown", mode_pulldown_en, 16'h1);
		chk("rw pin", {rw_oe, rw_pullup}, 16'h1);
		chk("strobe pin", {low_byte_strobe_oe,
			low_byte_strobe_pullup}, 16'h1);
		if (!m[0]) chk("dbe pullup", data_bus_enable_pullup, 16'h1);
		sys_rst <= 1'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	initial begin
		logic [15:0] r, a, d;
		logic [7:0] v;
		logic w, s;
		int c0, e0;
		void'($urandom(55));
		do_reset(3'h7);
		reg_read(MEBP_REG_STATUS, v);
		chk("mode", v[2:0], 16'h7);
		reg_read(MEBP_REG_PIN_ASSIGN, v);
		chk("pin assign", v, MEBP_PIN_ASSIGN_RST);
		chk("dbe enable", data_bus_enable_oe, 16'h1);
		c0 = n_beat;
		access(1'h1, 1'h1, 16'h1234, 16'h5678, r);
		chk("no enable beats", n_beat - c0, 16'h0);
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h03);
		for (int i = 0; i < 14; i++) begin
			w = 1'($urandom);
			s = w ? 1'($urandom) : 1'h1;
			a = (i == 0) ? 16'hFFFE : 16'($urandom);
			if (!w) a[0] = 1'h0;
			d = 16'($urandom);
			e0 = n_dbe;
			c0 = n_beat;
			access(w, s, a, d, r);
			chk("address", lat_addr, a);
			chk("beats", n_beat - c0, 16'h1);
			chk("rw level", lat_rw, !w);
			chk("dbe lows", n_dbe - e0, w ? 16'h0 : 16'h2);
			if (w) chk("strobe", lat_strb, a[0] == s);
			if (w && s) chk("write data", lat_wdata, d);
			if (!w) chk("read data", r, exp_word(a));
		end
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h13);
		e0 = n_dbe;
		access(1'h0, 1'h1, 16'h0F00, 16'h0000, r);
		chk("stretched dbe", n_dbe - e0, 16'h1);
		chk("stretched read", r, exp_word(16'h0F00));
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h01);
		c0 = n_beat;
		access(1'h1, 1'h0, 16'h2001, 16'h00AA, r);
		chk("low byte beats", n_beat - c0, 16'h0);
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h08);
		queue_state <= 4'($urandom);
		repeat (8) @(posedge sys_clk);
		@(posedge sys_clk iff bus_clock_out);
		@(posedge sys_clk iff !bus_clock_out);
		@(posedge sys_clk);
		chk("queue low", {mode_select_b_out, mode_select_a_out},
			queue_state[1:0]);
		@(posedge sys_clk iff bus_clock_out);
		@(posedge sys_clk);
		chk("queue high", {mode_select_b_out, mode_select_a_out},
			queue_state[3:2]);
		chk("queue drive", {mode_select_b_oe, mode_select_a_oe}, 16'h3);
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h40);
		for (int k = 0; k < 2; k++) begin
			mode_pins[2] <= k[0];
			repeat (4) @(posedge sys_clk);
			chk("tag high", tag_high_input, k[0]);
		end
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h00);
		mode_pins[2] <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk("debug rx", dbg_rx, 16'h0);
		do_reset(3'h5);
		reg_write(MEBP_REG_PIN_ASSIGN, 8'h03);
		a = 16'($urandom) & 16'hFFFE;
		c0 = n_beat;
		access(1'h0, 1'h1, a, 16'h0000, r);
		chk("narrow beats", n_beat - c0, 16'h2);
		chk("narrow word", r, exp_word(a));
		chk("second address", lat_addr, a | 16'h0001);
		do_reset(3'h6);
		chk("single chip ready", acc_ready, 16'h0);
		chk("dbe pullup", data_bus_enable_pullup, 16'h1);
		v = 8'($urandom);
		reg_write(MEBP_REG_UPPER_DIR, 8'hFF);
		reg_write(MEBP_REG_UPPER_DATA, v);
		repeat (2) @(posedge sys_clk);
		chk("gpio port", {upper_bus_port_oe, upper_bus_port_out},
			{8'hFF, v});
		finish_test();
	end
endmodule
`default_nettype wire
